// >>> bench/kbd_link_model.sv
/*
 Serial side model: offers received bytes to the controller and takes
 bytes meant for the keyboard, logging them in arrival order.
 Assumes the controller's ready/valid timing on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module kbd_link_model (
	// Clock
	input wire logic clk_sys,
	// Received byte link
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_aux,
	output logic rx_par_err,
	input wire logic rx_ready,
	// Keyboard byte link
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	// Test control
	input wire logic tx_stall
);
	logic [7:0] tx_log [$];
	// Counts offered bytes that were never accepted
	int n_hang = 0;

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_aux = 1'b0;
		rx_par_err = 1'b0;
	end

	assign tx_ready = tx_valid && !tx_stall;

	always @(posedge clk_sys) begin
		if (tx_valid && tx_ready) begin
			tx_log.push_back(tx_data);
		end
	end

	// Byte held until an edge sees ready; inverted afterwards so stale data never looks valid
	task automatic send(input logic [7:0] d, input logic aux, input logic par);
		int n;
		n = 0;
		@(posedge clk_sys);
		#1;
		rx_valid = 1'b1;
		rx_data = d;
		rx_aux = aux;
		rx_par_err = par;
		while (rx_ready !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (rx_ready !== 1'b1) begin
			n_hang++;
		end
		@(posedge clk_sys);
		#1;
		rx_valid = 1'b0;
		rx_data = ~d;
		rx_aux = ~aux;
		rx_par_err = ~par;
	endtask
endmodule // kbd_link_model
`default_nettype wire

// >>> bench/tb.sv
/*
 Self-checking bench for the keyboard controller host interface.
 Assumes the serial side model and 100 MHz clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] io_addr = 16'h0000;
	logic io_wr = 1'b0;
	logic io_rd = 1'b0;
	logic [7:0] io_wdata = 8'h00;
	logic [7:0] io_rdata;
	logic cfg_wr = 1'b0;
	logic [1:0] cfg_sel = 2'h0;
	logic [7:0] cfg_wdata = 8'h00;
	logic rx_valid, rx_aux, rx_par, rx_ready, tx_valid, tx_ready;
	logic [7:0] rx_data;
	logic [7:0] tx_data;
	logic kbd_timeout = 1'b0;
	logic tx_stall = 1'b0;
	logic kbd_off, aux_off, xlat_on, irq_kbd, irq_aux;
	logic inh_n = 1'b1;
	logic kclk = 1'b1;
	logic kdat = 1'b1;
	logic aclk = 1'b1;
	logic adat = 1'b1;
	int err_total = 0;
	int n_tests = 0;
	logic [7:0] rd;
	logic [15:0] dport = kbd_host_pkg::DATA_PORT_RST;
	logic [15:0] cport = kbd_host_pkg::CMD_PORT_RST;
	logic [7:0] cbv [3] = '{8'h47, 8'hb8, 8'h03};
	logic [7:0] pwb [3] = '{8'h1e, 8'h30, 8'h00};
	logic [7:0] codes [6] = '{8'h01, 8'h03, 8'h00, 8'h01, 8'h03, 8'h00};

	always #5 clk_sys = ~clk_sys;

	keyboard_ctrl_host_interface i_keyboard_ctrl_host_interface (
		.clk_sys(clk_sys), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
		.cfg_wdata(cfg_wdata), .kbd_rx_valid(rx_valid), .kbd_rx_data(rx_data),
		.kbd_rx_aux(rx_aux), .kbd_rx_par_err(rx_par), .kbd_rx_ready(rx_ready),
		.kbd_timeout(kbd_timeout), .kbd_tx_valid(tx_valid), .kbd_tx_data(tx_data),
		.kbd_tx_ready(tx_ready), .kbd_off(kbd_off), .aux_off(aux_off), .xlat_on(xlat_on),
		.inhibit_sw_n(inh_n), .kclk_pin(kclk), .kdat_pin(kdat), .aclk_pin(aclk),
		.adat_pin(adat), .irq_kbd(irq_kbd), .irq_aux(irq_aux)
	);

	kbd_link_model i_kbd_link_model (
		.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_aux(rx_aux),
		.rx_par_err(rx_par), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .tx_stall(tx_stall)
	);

	// ****************************************
	// Host cycle tasks
	// ****************************************
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(posedge clk_sys);
		#1;
		io_wr = 1'b0;
	endtask

	task automatic io_read(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#1;
		io_addr = a;
		io_rd = 1'b1;
		@(posedge clk_sys);
		#1;
		io_rd = 1'b0;
		d = io_rdata;
	endtask

	task automatic cfg_write(input logic [1:0] s, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		cfg_sel = s;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		@(posedge clk_sys);
		#1;
		cfg_wr = 1'b0;
	endtask

	// Poll status; the bit index picks buffer full (0) or input busy (1)
	task automatic wait_st(input int b, input logic lvl);
		logic [7:0] s;
		int n;
		n = 0;
		s = ~{8{lvl}};
		while (s[b] !== lvl && n < 50) begin
			io_read(cport, s);
			n++;
		end
		chk("status_wait", {7'h00, lvl}, {7'h00, s[b]});
	endtask

	task automatic cmd_reply(input logic [7:0] c, input logic [7:0] exp, input string what);
		logic [7:0] r;
		io_write(cport, c);
		wait_st(0, 1'b1);
		io_read(dport, r);
		chk(what, exp, r);
	endtask

	task automatic test_end(input string name);
		$display("test %s done, mismatches so far %0d", name, err_total);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		#100000;
		err_total++;
		$display("ERROR watchdog expected done seen hang");
		test_done();
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		io_read(cport, rd);
		chk("status_rst", 8'h10, rd);
		cmd_reply(kbd_host_pkg::C_SELF, kbd_host_pkg::R_SELF_OK, "self");
		io_read(cport, rd);
		chk("status_cmd", 8'h18, rd);
		test_end("self");
		foreach (cbv[i]) begin
			io_write(cport, kbd_host_pkg::C_WR_CB);
			io_write(dport, cbv[i]);
			wait_st(1, 1'b0);
			chk("cb_ctl", {5'h00, cbv[i][6:4]}, {5'h00, xlat_on, aux_off, kbd_off});
			io_read(cport, rd);
			chk("sys_flag", {7'h00, cbv[i][2]}, {7'h00, rd[2]});
			cmd_reply(kbd_host_pkg::C_RD_CB, cbv[i], "cb_read");
		end
		io_write(cport, kbd_host_pkg::C_KBD_DIS);
		io_write(cport, kbd_host_pkg::C_AUX_DIS);
		wait_st(1, 1'b0);
		chk("cb_off", 8'h03, {6'h00, aux_off, kbd_off});
		io_write(cport, kbd_host_pkg::C_KBD_EN);
		io_write(cport, kbd_host_pkg::C_AUX_EN);
		wait_st(1, 1'b0);
		chk("cb_on", 8'h00, {6'h00, aux_off, kbd_off});
		test_end("command byte");
		i_kbd_link_model.send(8'h1c, 1'b0, 1'b1);
		io_read(cport, rd);
		chk("status_kbd", 8'h99, rd);
		chk("irq_kbd", 8'h01, {7'h00, irq_kbd});
		io_read(cport, rd);
		chk("status_again", 8'h99, rd);
		io_read(dport, rd);
		chk("ob_kbd", 8'h1c, rd);
		chk("irq_kbd_off", 8'h00, {7'h00, irq_kbd});
		i_kbd_link_model.send(8'h5a, 1'b1, 1'b0);
		io_read(cport, rd);
		chk("status_aux", 8'h39, rd);
		chk("irq_aux", 8'h02, {6'h00, irq_aux, irq_kbd});
		io_read(dport, rd);
		chk("ob_aux", 8'h5a, rd);
		test_end("receive");
		tx_stall = 1'b1;
		io_write(dport, 8'hed);
		wait_st(1, 1'b0);
		io_write(dport, 8'hf4);
		repeat (4) @(posedge clk_sys);
		io_read(cport, rd);
		chk("status_busy", 8'h12, rd);
		tx_stall = 1'b0;
		wait_st(1, 1'b0);
		repeat (4) @(posedge clk_sys);
		chk("tx_first", 8'hed, i_kbd_link_model.tx_log[0]);
		chk("tx_second", 8'hf4, i_kbd_link_model.tx_log[1]);
		test_end("transmit");
		cmd_reply(kbd_host_pkg::C_PW_TEST, kbd_host_pkg::R_PW_NONE, "pw_none");
		io_write(cport, kbd_host_pkg::C_PW_LOAD);
		foreach (pwb[i]) begin
			wait_st(1, 1'b0);
			io_write(dport, pwb[i]);
		end
		cmd_reply(kbd_host_pkg::C_PW_TEST, kbd_host_pkg::R_PW_SET, "pw_set");
		chk("tx_count", 8'h02, 8'(i_kbd_link_model.tx_log.size()));
		io_write(cport, kbd_host_pkg::C_PW_EN);
		wait_st(1, 1'b0);
		i_kbd_link_model.send(8'h1e, 1'b0, 1'b0);
		i_kbd_link_model.send(8'h30, 1'b0, 1'b0);
		repeat (3) @(posedge clk_sys);
		io_read(cport, rd);
		chk("pw_swallow", 8'h00, {7'h00, rd[0]});
		i_kbd_link_model.send(8'h2b, 1'b0, 1'b0);
		wait_st(0, 1'b1);
		io_read(dport, rd);
		chk("pw_unlocked", 8'h2b, rd);
		test_end("password");
		// Only stuck-low faults are detectable since the lines are never driven here
		for (int i = 0; i < 6; i++) begin
			kclk = (i != 0);
			kdat = (i != 1);
			aclk = (i != 3);
			adat = (i != 4);
			repeat (4) @(posedge clk_sys);
			#1;
			cmd_reply(i < 3 ? kbd_host_pkg::C_KBD_TEST : kbd_host_pkg::C_AUX_TEST, codes[i],
				"itest");
		end
		inh_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		io_read(cport, rd);
		chk("inhibit", 8'h00, {7'h00, rd[4]});
		inh_n = 1'b1;
		kbd_timeout = 1'b1;
		@(posedge clk_sys);
		#1;
		kbd_timeout = 1'b0;
		io_read(cport, rd);
		chk("timeout", 8'h01, {7'h00, rd[6]});
		test_end("pins");
		cfg_write(kbd_host_pkg::CFG_DATA_HI, 8'h02);
		cfg_write(kbd_host_pkg::CFG_DATA_LO, 8'h00);
		cfg_write(kbd_host_pkg::CFG_CMD_HI, 8'h03);
		cfg_write(kbd_host_pkg::CFG_CMD_LO, 8'h10);
		dport = 16'h0200;
		cport = 16'h0310;
		cmd_reply(kbd_host_pkg::C_SELF, kbd_host_pkg::R_SELF_OK, "reloc");
		io_read(16'h0064, rd);
		chk("unmapped", 8'hff, rd);
		test_end("relocation");
		chk("rx_hang", 8'h00, 8'(i_kbd_link_model.n_hang));
		test_done();
	end
endmodule // tb
`default_nettype wire

// >>> rtl/kbd_host_pkg.sv
/*
 Constants for the keyboard controller host interface: port defaults,
 status and command byte fields, command codes and answer codes.
 Assumes a single 100 MHz clock domain.
*/
package kbd_host_pkg;
	// Default I/O locations, relocatable through the config bytes
	localparam logic [15:0] DATA_PORT_RST = 16'h0060;
	localparam logic [15:0] CMD_PORT_RST = 16'h0064;
	// Config byte selectors
	localparam logic [1:0] CFG_DATA_HI = 2'h0;
	localparam logic [1:0] CFG_DATA_LO = 2'h1;
	localparam logic [1:0] CFG_CMD_HI = 2'h2;
	localparam logic [1:0] CFG_CMD_LO = 2'h3;
	// Status bit positions
	localparam int ST_OBF = 0;
	localparam int ST_IBF = 1;
	localparam int ST_SYS = 2;
	localparam int ST_CMD = 3;
	localparam int ST_INH = 4;
	localparam int ST_AUX = 5;
	localparam int ST_TMO = 6;
	localparam int ST_PAR = 7;
	// Command byte fields; bits 7 and 3 read back as written
	localparam int CB_KIE = 0;
	localparam int CB_AIE = 1;
	localparam int CB_SYS = 2;
	localparam int CB_KDIS = 4;
	localparam int CB_ADIS = 5;
	localparam int CB_XLAT = 6;
	localparam logic [7:0] CB_RST = 8'h00;
	// Command codes
	localparam logic [7:0] C_RD_CB = 8'h20;
	localparam logic [7:0] C_WR_CB = 8'h60;
	localparam logic [7:0] C_PW_TEST = 8'ha4;
	localparam logic [7:0] C_PW_LOAD = 8'ha5;
	localparam logic [7:0] C_PW_EN = 8'ha6;
	localparam logic [7:0] C_AUX_DIS = 8'ha7;
	localparam logic [7:0] C_AUX_EN = 8'ha8;
	localparam logic [7:0] C_AUX_TEST = 8'ha9;
	localparam logic [7:0] C_SELF = 8'haa;
	localparam logic [7:0] C_KBD_TEST = 8'hab;
	localparam logic [7:0] C_KBD_DIS = 8'had;
	localparam logic [7:0] C_KBD_EN = 8'hae;
	// Answer codes
	localparam logic [7:0] R_PW_SET = 8'hfa;
	localparam logic [7:0] R_PW_NONE = 8'hf1;
	localparam logic [7:0] R_SELF_OK = 8'h55;
	localparam logic [7:0] R_OK = 8'h00;
	localparam logic [7:0] R_CLK_LO = 8'h01;
	localparam logic [7:0] R_CLK_HI = 8'h02;
	localparam logic [7:0] R_DAT_LO = 8'h03;
	localparam logic [7:0] R_DAT_HI = 8'h04;
	// Parameter wait modes, one-hot
	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_CB = 3'b010,
		M_PW = 3'b100
	} mode_t;
endpackage

// >>> rtl/keyboard_ctrl_host_interface.sv
/*
 Host side of a PS/2 keyboard/mouse controller: output buffer, input
 buffer, status, command byte and command decoder.
 Assumes host strobes and the byte link run on clk_sys; the interface
 test line levels and the inhibit switch come from pins.
*/
// What this block does
// - Read-only output buffer at data port
// - Writes load input buffer, flag data/command
// - Data bytes go to keyboard unless parameter
// - Both port bases relocatable by config bytes
// - Status readable anytime without side effects
// - Bits 0,1 show output/input buffer full
// - Bit 2 mirrors system flag, resets 0
// - Bit 3 shows last write was command
// - Bit 4 shows inhibit switch, 0 inhibited
// - Bit 5 shows buffered byte from mouse
// - Bit 6 shows timeout error
// - Bit 7 shows even parity error
// - Commands read and write the command byte
// - Command byte fields at fixed bit positions
// - Password test answers loaded or not loaded
// - Password load until a zero byte
// - Password enable starts keystroke matching
// - Auxiliary interface test returns line code
// - Self test answers 55h on success
// - Keyboard interface test returns line code
// - Interrupt on buffered byte, when enabled
`timescale 1ns/1ns
`default_nettype none
module keyboard_ctrl_host_interface #(
	parameter int PW_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Host I/O cycles
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	// Port relocation bytes
	input wire logic cfg_wr,
	input wire logic [1:0] cfg_sel,
	input wire logic [7:0] cfg_wdata,
	// Received bytes from the serial side
	input wire logic kbd_rx_valid,
	input wire logic [7:0] kbd_rx_data,
	input wire logic kbd_rx_aux,
	input wire logic kbd_rx_par_err,
	output logic kbd_rx_ready,
	input wire logic kbd_timeout,
	// Bytes for the keyboard
	output logic kbd_tx_valid,
	output logic [7:0] kbd_tx_data,
	input wire logic kbd_tx_ready,
	// Command byte controls for the serial side
	output logic kbd_off,
	output logic aux_off,
	output logic xlat_on,
	// Pins
	input wire logic inhibit_sw_n,
	input wire logic kclk_pin,
	input wire logic kdat_pin,
	input wire logic aclk_pin,
	input wire logic adat_pin,
	// Interrupts to the host
	output logic irq_kbd,
	output logic irq_aux
);
	localparam int AW = $clog2(PW_DEPTH);
	localparam logic [AW-1:0] IDX_ONE = {{(AW-1){1'b0}}, 1'b1};

	logic [15:0] data_base_q, cmd_base_q;
	logic [7:0] ob_q, ib_q, cb_q, status;
	logic obf_q, ibf_q, ib_cmd_q, aux_q, tmo_q, par_q;
	logic obf_d, aux_d;
	logic [4:0] sync1_q, sync2_q;
	kbd_host_pkg::mode_t mode_q;
	logic pw_loaded_q, pw_active_q;
	logic [AW-1:0] pw_len_q, pw_idx_q, match_idx_q;
	logic hit_data, hit_cmd, rd_data, rx_take, rx_to_ob;
	logic ib_take, resp_en, tx_go;
	logic [7:0] resp_byte;

	pw_mem_if #(.AW(AW)) pw_bus ();

	pw_mem #(.DEPTH(PW_DEPTH), .AW(AW)) u_pw_mem (
		.clk_sys(clk_sys),
		.bus(pw_bus)
	);

	// ****************************************
	// Port decode and relocation
	// ****************************************
	assign hit_data = (io_addr == data_base_q);
	assign hit_cmd = (io_addr == cmd_base_q);
	assign rd_data = io_rd & hit_data;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			data_base_q <= kbd_host_pkg::DATA_PORT_RST;
			cmd_base_q <= kbd_host_pkg::CMD_PORT_RST;
		end else if (cfg_wr) begin
			case (cfg_sel)
				kbd_host_pkg::CFG_DATA_HI: data_base_q[15:8] <= cfg_wdata;
				kbd_host_pkg::CFG_DATA_LO: data_base_q[7:0] <= cfg_wdata;
				kbd_host_pkg::CFG_CMD_HI: cmd_base_q[15:8] <= cfg_wdata;
				default: cmd_base_q[7:0] <= cfg_wdata;
			endcase
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Order: inhibit, kbd clock, kbd data, aux clock, aux data
	for (genvar i = 0; i < 5; i++) begin : g_sync
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				sync1_q[i] <= 1'b1;
				sync2_q[i] <= 1'b1;
			end else begin
				sync1_q[i] <= (i == 0) ? inhibit_sw_n : (i == 1) ? kclk_pin :
					(i == 2) ? kdat_pin : (i == 3) ? aclk_pin : adat_pin;
				sync2_q[i] <= sync1_q[i];
			end
		end
	end

	// ****************************************
	// Command decode
	// ****************************************
	assign rx_take = kbd_rx_valid & kbd_rx_ready;
	// While the password lock is armed, keystrokes are swallowed
	assign rx_to_ob = rx_take & ~(pw_active_q & ~kbd_rx_aux);

	always_comb begin
		ib_take = 1'b0;
		resp_en = 1'b0;
		tx_go = 1'b0;
		resp_byte = kbd_host_pkg::R_OK;
		if (ibf_q && !ib_cmd_q) begin
			if (mode_q != kbd_host_pkg::M_IDLE) begin
				ib_take = 1'b1;
			end else if (!kbd_tx_valid) begin
				ib_take = 1'b1;
				tx_go = 1'b1;
			end
		end else if (ibf_q) begin
			resp_en = 1'b1;
			case (ib_q)
				kbd_host_pkg::C_RD_CB: resp_byte = cb_q;
				kbd_host_pkg::C_PW_TEST: resp_byte = pw_loaded_q ?
					kbd_host_pkg::R_PW_SET : kbd_host_pkg::R_PW_NONE;
				kbd_host_pkg::C_SELF: resp_byte = kbd_host_pkg::R_SELF_OK;
				// The lines can only be seen stuck low; we never drive them
				kbd_host_pkg::C_AUX_TEST: resp_byte = !sync2_q[3] ? kbd_host_pkg::R_CLK_LO :
					!sync2_q[4] ? kbd_host_pkg::R_DAT_LO : kbd_host_pkg::R_OK;
				kbd_host_pkg::C_KBD_TEST: resp_byte = !sync2_q[1] ? kbd_host_pkg::R_CLK_LO :
					!sync2_q[2] ? kbd_host_pkg::R_DAT_LO : kbd_host_pkg::R_OK;
				default: resp_en = 1'b0;
			endcase
			// Answers wait for an empty buffer; received bytes go first
			ib_take = resp_en ? (!obf_q && !rx_take) : 1'b1;
		end
	end

	// ****************************************
	// Input buffer
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ibf_q <= 1'b0;
			ib_q <= 8'h00;
			ib_cmd_q <= 1'b0;
		end else if (io_wr && (hit_data || hit_cmd)) begin
			ibf_q <= 1'b1;
			ib_q <= io_wdata;
			ib_cmd_q <= hit_cmd;
		end else if (ib_take) begin
			ibf_q <= 1'b0;
		end
	end

	// ****************************************
	// Parameter wait mode and command byte
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mode_q <= kbd_host_pkg::M_IDLE;
		end else if (ib_take && ib_cmd_q) begin
			case (ib_q)
				kbd_host_pkg::C_WR_CB: mode_q <= kbd_host_pkg::M_CB;
				kbd_host_pkg::C_PW_LOAD: mode_q <= kbd_host_pkg::M_PW;
				default: mode_q <= kbd_host_pkg::M_IDLE;
			endcase
		end else if (ib_take) begin
			case (mode_q)
				kbd_host_pkg::M_CB: mode_q <= kbd_host_pkg::M_IDLE;
				kbd_host_pkg::M_PW: if (ib_q == 8'h00) begin
					mode_q <= kbd_host_pkg::M_IDLE;
				end
				default: mode_q <= kbd_host_pkg::M_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cb_q <= kbd_host_pkg::CB_RST;
		end else if (ib_take && !ib_cmd_q && mode_q == kbd_host_pkg::M_CB) begin
			cb_q <= ib_q;
		end else if (ib_take && ib_cmd_q) begin
			case (ib_q)
				kbd_host_pkg::C_AUX_DIS: cb_q[kbd_host_pkg::CB_ADIS] <= 1'b1;
				kbd_host_pkg::C_AUX_EN: cb_q[kbd_host_pkg::CB_ADIS] <= 1'b0;
				kbd_host_pkg::C_KBD_DIS: cb_q[kbd_host_pkg::CB_KDIS] <= 1'b1;
				kbd_host_pkg::C_KBD_EN: cb_q[kbd_host_pkg::CB_KDIS] <= 1'b0;
				default: cb_q <= cb_q;
			endcase
		end
	end

	// ****************************************
	// Password store and matching
	// ****************************************
	assign pw_bus.wr_en = ib_take && !ib_cmd_q && mode_q == kbd_host_pkg::M_PW &&
		ib_q != 8'h00 && pw_idx_q != AW'(PW_DEPTH - 1);
	assign pw_bus.addr = (mode_q == kbd_host_pkg::M_PW) ? pw_idx_q : match_idx_q;
	assign pw_bus.wdata = ib_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pw_idx_q <= '0;
			pw_len_q <= '0;
			pw_loaded_q <= 1'b0;
		end else if (ib_take && ib_cmd_q && ib_q == kbd_host_pkg::C_PW_LOAD) begin
			pw_idx_q <= '0;
		end else if (pw_bus.wr_en) begin
			pw_idx_q <= pw_idx_q + IDX_ONE;
		end else if (ib_take && mode_q == kbd_host_pkg::M_PW && ib_q == 8'h00) begin
			pw_len_q <= pw_idx_q;
			pw_loaded_q <= (pw_idx_q != '0);
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pw_active_q <= 1'b0;
			match_idx_q <= '0;
		end else if (ib_take && ib_cmd_q && ib_q == kbd_host_pkg::C_PW_EN) begin
			pw_active_q <= pw_loaded_q;
			match_idx_q <= '0;
		end else if (rx_take && pw_active_q && !kbd_rx_aux) begin
			if (kbd_rx_data != pw_bus.rdata) begin
				match_idx_q <= '0;
			end else if (match_idx_q + IDX_ONE == pw_len_q) begin
				pw_active_q <= 1'b0;
				match_idx_q <= '0;
			end else begin
				match_idx_q <= match_idx_q + IDX_ONE;
			end
		end
	end

	// ****************************************
	// Output buffer and its flags
	// ****************************************
	always_comb begin
		obf_d = obf_q & ~rd_data;
		// Bit 5 means a mouse byte is waiting, so it empties with the buffer
		aux_d = aux_q & ~rd_data;
		if (rx_to_ob) begin
			obf_d = 1'b1;
			aux_d = kbd_rx_aux;
		end else if (resp_en && ib_take) begin
			obf_d = 1'b1;
			aux_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			obf_q <= 1'b0;
			aux_q <= 1'b0;
			ob_q <= 8'h00;
			kbd_rx_ready <= 1'b0;
		end else begin
			obf_q <= obf_d;
			aux_q <= aux_d;
			kbd_rx_ready <= ~obf_d;
			if (rx_to_ob) begin
				ob_q <= kbd_rx_data;
			end else if (resp_en && ib_take) begin
				ob_q <= resp_byte;
			end
		end
	end

	// Error bits hold until the next received byte
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tmo_q <= 1'b0;
			par_q <= 1'b0;
		end else begin
			if (kbd_timeout) begin
				tmo_q <= 1'b1;
			end else if (rx_take) begin
				tmo_q <= 1'b0;
			end
			if (rx_take) begin
				par_q <= kbd_rx_par_err;
			end
		end
	end

	// ****************************************
	// Status and host reads
	// ****************************************
	assign status = {par_q, tmo_q, aux_q, sync2_q[0], ib_cmd_q,
		cb_q[kbd_host_pkg::CB_SYS], ibf_q, obf_q};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			io_rdata <= 8'h00;
		end else if (rd_data) begin
			io_rdata <= ob_q;
		end else if (io_rd && hit_cmd) begin
			io_rdata <= status;
		end else if (io_rd) begin
			io_rdata <= 8'hff;
		end
	end

	// ****************************************
	// Keyboard transmit, controls, interrupts
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			kbd_tx_valid <= 1'b0;
			kbd_tx_data <= 8'h00;
		end else if (tx_go) begin
			kbd_tx_valid <= 1'b1;
			kbd_tx_data <= ib_q;
		end else if (kbd_tx_ready) begin
			kbd_tx_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			kbd_off <= 1'b0;
			aux_off <= 1'b0;
			xlat_on <= 1'b0;
			irq_kbd <= 1'b0;
			irq_aux <= 1'b0;
		end else begin
			kbd_off <= cb_q[kbd_host_pkg::CB_KDIS];
			aux_off <= cb_q[kbd_host_pkg::CB_ADIS];
			xlat_on <= cb_q[kbd_host_pkg::CB_XLAT];
			irq_kbd <= obf_d & ~aux_d & cb_q[kbd_host_pkg::CB_KIE];
			irq_aux <= obf_d & aux_d & cb_q[kbd_host_pkg::CB_AIE];
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_OBF_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
		(rd_data && !rx_to_ob && !(resp_en && ib_take)) |=> !obf_q)
		else $error("output buffer full stayed set after host read");
	AST_IBF_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
		(io_wr && hit_data) |=> (ibf_q && !ib_cmd_q && ib_q == $past(io_wdata)))
		else $error("data write did not fill input buffer");
	AST_CMD_FLAG: assert property (@(posedge clk_sys) disable iff (!rstn)
		(io_wr && hit_cmd) |=> status[kbd_host_pkg::ST_CMD])
		else $error("command flag not set after command write");
	AST_SYSFLAG: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ib_take && !ib_cmd_q && mode_q == kbd_host_pkg::M_CB)
		|=> status[kbd_host_pkg::ST_SYS] == $past(ib_q[kbd_host_pkg::CB_SYS]))
		else $error("system flag differs from command byte");
	AST_SELFTEST: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ib_take && ib_cmd_q && ib_q == kbd_host_pkg::C_SELF)
		|=> (obf_q && ob_q == kbd_host_pkg::R_SELF_OK))
		else $error("self test answer missing");
	AST_PWTEST: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ib_take && ib_cmd_q && ib_q == kbd_host_pkg::C_PW_TEST && !pw_loaded_q)
		|=> ob_q == kbd_host_pkg::R_PW_NONE)
		else $error("wrong password test answer");
	AST_STATUS_READ: assert property (@(posedge clk_sys) disable iff (!rstn)
		(io_rd && hit_cmd && !hit_data && !io_wr && !rx_take && !ib_take)
		|=> ($stable(obf_q) && $stable(ibf_q) && io_rdata == $past(status)))
		else $error("status read disturbed controller state");
	AST_FORWARD: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ibf_q && !ib_cmd_q && mode_q == kbd_host_pkg::M_IDLE && !kbd_tx_valid)
		|=> (kbd_tx_valid && kbd_tx_data == $past(ib_q)))
		else $error("data byte not forwarded to keyboard");
	AST_WRCB: assert property (@(posedge clk_sys) disable iff (!rstn)
		(ib_take && !ib_cmd_q && mode_q == kbd_host_pkg::M_CB)
		|=> (cb_q == $past(ib_q) && mode_q == kbd_host_pkg::M_IDLE))
		else $error("command byte not written");
	AST_IRQ: assert property (@(posedge clk_sys) disable iff (!rstn)
		(rx_to_ob && !kbd_rx_aux && cb_q[kbd_host_pkg::CB_KIE]) |=> irq_kbd)
		else $error("keyboard interrupt missing");
	AST_AUX_CLEAR: assert property (@(posedge clk_sys) disable iff (!rstn)
		(rd_data && !rx_to_ob) |=> !status[kbd_host_pkg::ST_AUX])
		else $error("mouse flag stayed set after host read");
endmodule // keyboard_ctrl_host_interface
`default_nettype wire

// >>> rtl/pw_mem.sv
/*
 Small byte store for the password, registered read data.
 Assumes one clock; contents are undefined after reset.
*/
`timescale 1ns/1ns
`default_nettype none
module pw_mem #(
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock
	input wire logic clk_sys,
	// Access
	pw_mem_if.mem bus
);
	logic [7:0] mem_q [DEPTH];

	always_ff @(posedge clk_sys) begin
		if (bus.wr_en) begin
			mem_q[bus.addr] <= bus.wdata;
		end
		bus.rdata <= mem_q[bus.addr];
	end
endmodule // pw_mem
`default_nettype wire

// >>> rtl/pw_mem_if.sv
/*
 Port bundle between the controller and its password store.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface pw_mem_if #(parameter int AW = 3);
	logic wr_en;
	logic [AW-1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctl (output wr_en, output addr, output wdata, input rdata);
	modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire
